// file: crs_pkg.sv
// constants and types for the continuous buffer reload sequencer
package crs_pkg;
  // phase index = (main cycle - 1) * 4 + (phase - 1), t1.1 = 0 .. t4.4 = 15
  localparam logic [3:0] PH_T1_1 = 4'h0;
  localparam logic [3:0] PH_T1_2 = 4'h1;
  localparam logic [3:0] PH_T1_3 = 4'h2;
  localparam logic [3:0] PH_T2_1 = 4'h4;
  localparam logic [3:0] PH_T2_2 = 4'h5;
  localparam logic [3:0] PH_T2_3 = 4'h6;
  localparam logic [3:0] PH_T3_1 = 4'h8;
  localparam logic [3:0] PH_T3_2 = 4'h9;
  localparam logic [3:0] PH_T3_3 = 4'ha;
  localparam logic [3:0] PH_T4_1 = 4'hc;
  localparam logic [3:0] PH_T4_2 = 4'hd;
  localparam logic [3:0] PH_T4_3 = 4'he;
  localparam logic [3:0] PH_T4_4 = 4'hf;
  // control memory layout (octal 20, octal 200)
  localparam logic [15:0] RELOAD_BASE = 16'h0010;
  localparam logic [15:0] UPPER_OFS = 16'h0080;
  localparam logic [15:0] IN_BUF_BASE = 16'h0040;
  localparam logic [15:0] OUT_BUF_BASE = 16'h0060;
  // register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_CNT = 4'h8;
  localparam logic CTRL_RST = 1'b0;
  localparam int ACW_MODE_BIT = 17;
  // whole state of the sequencer
  typedef struct packed {
    logic [3:0] ph;
    logic req;
    logic seq;
    logic pf;
    logic inh;
    logic ovr;
    logic [15:0] s0;
    logic [15:0] s1;
    logic [17:0] z0;
    logic cm_init;
    logic cm_we;
    logic [15:0] cm_addr;
    logic [17:0] cm_wdata;
    logic waitreq;
    logic [31:0] rdata;
    logic enable;
    logic [15:0] count;
  } crs_state_t;
endpackage

// file: crs_sequencer.sv
// continuous reload sequencer: timing, address build, control memory, bus slave
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Contract
// RQ1: start alongside transfer sequence tail, memory free
// RQ2: t3.1 fetches reload current word to data
// RQ3: second reference stores it to buffer location
// RQ4: addresses built from channel and transfer type
// RQ5: current-word addresses have low bit one
// RQ6: two more references fetch, store terminal word
// RQ7: terminal-word addresses even, one below current
// RQ8: t2.1 address routed through secondary register
// RQ9: t4.4 sets request on match with bit17
// RQ10: t2.2 sets sequence flag on listed conditions
// RQ11: overlap first sequence unless dual or external
// RQ12: t3.1 phase flag, address, memory, clears
// RQ13: t1.1 load primary and secondary, start memory
// RQ14: t2.1 clear sequence, secondary to primary
// RQ15: t2.3 clear phase flag, drop load inhibit
// RQ16: overrides act on primary transfers only
// RQ17: upper channels add octal 200 to address
// RQ18: terminal word at octal 20 plus twice channel
// RQ19: reload only when terminal word bit17 set
module crs_sequencer #(
  parameter int AW = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm register slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // transfer sequence side
  input wire logic io_seq_active,
  input wire logic [15:0] io_b_addr,
  input wire logic io1_final,
  input wire logic dual_mode,
  input wire logic externally_specified_mode,
  input wire logic term_flag,
  input wire logic [3:0] xl_chan,
  input wire logic xl_output,
  // control memory side
  input wire logic cm_free,
  input wire logic cm_rvalid,
  input wire logic [17:0] cm_rdata,
  output logic cm_init,
  output logic cm_we,
  output logic [AW-1:0] cm_addr,
  output logic [17:0] cm_wdata,
  // flags seen by the transfer sequences
  output logic reload_request_flag,
  output logic reload_sequence_flag,
  output logic reload_phase_flag,
  output logic translator_override_low,
  output logic translator_override_high,
  output logic [3:0] timing_phase
);

  crs_pkg::crs_state_t q;
  crs_pkg::crs_state_t d;

  // translator address: override picks the reload pair, else the buffer words
  function automatic logic [15:0] xlat_addr(input logic [3:0] ch, input logic outp,
                                            input logic ovr);
    logic [15:0] base;
    logic [15:0] a;
    base = ovr ? crs_pkg::RELOAD_BASE :
           (outp ? crs_pkg::OUT_BUF_BASE : crs_pkg::IN_BUF_BASE); // [RQ4] [RQ16]
    a = base + {12'h000, ch[2:0], 1'b0}; // [RQ18]
    if (ch[3])
      a = a + crs_pkg::UPPER_OFS; // [RQ17]
    return a;
  endfunction

  logic match;
  logic start_ok;
  logic bus_req;
  logic bus_take;
  logic bus_done;
  logic [15:0] prim_addr;
  logic [15:0] sec_addr;

  // terminal match only counts when the reload mode bit is set
  assign match = (io_b_addr == q.z0[15:0]) && q.z0[crs_pkg::ACW_MODE_BIT]; // [RQ9] [RQ19]
  // sequence may start only with memory free and a legal overlap
  assign start_ok = q.req && cm_free &&
                    (io1_final || dual_mode || (externally_specified_mode && term_flag)); // [RQ1] [RQ10]
  assign prim_addr = xlat_addr(xl_chan, xl_output, q.ovr);
  // secondary path never sees the override
  assign sec_addr = xlat_addr(xl_chan, xl_output, 1'b0); // [RQ16]
  assign bus_req = avs_read || avs_write;
  assign bus_take = bus_req && q.waitreq;
  // writes commit only at the edge where the master sees waitrequest low,
  // so a master that gives up early never leaves a half-taken write behind
  assign bus_done = bus_req && !q.waitreq;

  // next-state logic for the whole sequencer
  always_comb
  begin
    d = q;
    d.ph = q.ph + 4'h1;
    d.cm_init = 1'b0;
    d.cm_we = 1'b0;
    // memory data register loads unless inhibited
    if (cm_rvalid && !q.inh)
      d.z0 = cm_rdata;
    case (q.ph)
      crs_pkg::PH_T4_4:
      begin
        if (io_seq_active && q.enable && match && !q.seq)
          d.req = 1'b1; // [RQ9]
        if (q.seq)
          d.s1 = 16'h0000;
      end
      crs_pkg::PH_T2_2:
      begin
        if (start_ok && !q.seq)
        begin
          d.seq = 1'b1; // [RQ10] [RQ11]
          d.ovr = 1'b1;
        end
      end
      crs_pkg::PH_T3_1:
      begin
        if (q.seq)
        begin
          // fetch reload current-address word, odd address
          d.pf = 1'b1; // [RQ12]
          d.s0 = prim_addr | 16'h0001; // [RQ5]
          d.cm_addr = prim_addr | 16'h0001; // [RQ2]
          d.cm_init = 1'b1;
          d.z0 = 18'h00000;
          d.req = 1'b0;
          if (cm_rvalid && !q.inh)
            d.z0 = cm_rdata;
        end
      end
      crs_pkg::PH_T3_2:
      begin
        d.ovr = 1'b0;
      end
      crs_pkg::PH_T3_3, crs_pkg::PH_T1_3:
      begin
        if (q.seq)
          d.inh = 1'b1;
      end
      crs_pkg::PH_T4_1:
      begin
        if (q.seq)
        begin
          // store current word into the buffer's own odd location
          d.s0 = prim_addr | 16'h0001; // [RQ3] [RQ5]
          d.cm_addr = prim_addr | 16'h0001;
          d.cm_wdata = q.z0;
          d.cm_we = 1'b1;
          d.cm_init = 1'b1;
        end
      end
      crs_pkg::PH_T4_2:
      begin
        if (q.seq)
          d.ovr = 1'b1;
      end
      crs_pkg::PH_T4_3:
      begin
        d.inh = 1'b0;
      end
      crs_pkg::PH_T1_1:
      begin
        if (q.seq)
        begin
          // fetch terminal word (even); park its store address in secondary
          d.s0 = prim_addr; // [RQ6] [RQ7] [RQ13]
          d.cm_addr = prim_addr;
          d.cm_init = 1'b1;
          d.z0 = 18'h00000;
          d.s1 = sec_addr; // [RQ8]
          if (cm_rvalid && !q.inh)
            d.z0 = cm_rdata;
        end
      end
      crs_pkg::PH_T1_2:
      begin
        d.ovr = 1'b0;
      end
      crs_pkg::PH_T2_1:
      begin
        if (q.seq)
        begin
          // no direct translator path here, so the secondary feeds primary
          d.seq = 1'b0; // [RQ14]
          d.s0 = q.s1; // [RQ8]
          d.cm_addr = q.s1; // [RQ6] [RQ7]
          d.cm_wdata = q.z0;
          d.cm_we = 1'b1;
          d.cm_init = 1'b1;
          d.count = q.count + 16'h0001;
        end
      end
      crs_pkg::PH_T2_3:
      begin
        d.pf = 1'b0; // [RQ15]
        d.inh = 1'b0;
      end
      default:
      begin
        d.ph = q.ph + 4'h1;
      end
    endcase
    // one-wait bus slave: answer one cycle after the request appears
    d.waitreq = !bus_take;
    if (bus_take && avs_read)
    begin
      case (avs_address)
        crs_pkg::REG_CTRL: d.rdata = {31'h00000000, q.enable};
        crs_pkg::REG_STAT: d.rdata = {23'h000000, q.ovr, q.inh, q.pf, q.seq, q.req, q.ph};
        crs_pkg::REG_CNT: d.rdata = {16'h0000, q.count};
        default: d.rdata = 32'h00000000;
      endcase
    end
    if (bus_done && avs_write)
    begin
      case (avs_address)
        crs_pkg::REG_CTRL: d.enable = avs_writedata[0];
        crs_pkg::REG_CNT: d.count = 16'h0000;
        default: d.enable = q.enable;
      endcase
    end
  end

  // single state register; sync reset keeps everything constant
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '0;
      q.waitreq <= 1'b1;
      q.enable <= crs_pkg::CTRL_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.waitreq;
  assign cm_init = q.cm_init;
  assign cm_we = q.cm_we;
  assign cm_addr = q.cm_addr[AW-1:0];
  assign cm_wdata = q.cm_wdata;
  assign reload_request_flag = q.req;
  assign reload_sequence_flag = q.seq;
  assign reload_phase_flag = q.pf;
  // override drives the low gate low and the high gate high
  assign translator_override_low = !q.ovr;
  assign translator_override_high = q.ovr;
  assign timing_phase = q.ph;

  // checks on the sequence
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_seq_start_cond: assert property ( // [RQ10]
    $rose(q.seq) |-> $past(q.ph) == crs_pkg::PH_T2_2 && $past(start_ok))
    else $error("sequence flag set without start condition");
  a_req_set_match: assert property ( // [RQ9]
    $rose(q.req) |-> $past(q.ph) == crs_pkg::PH_T4_4 && $past(match))
    else $error("request flag set without terminal match");
  a_fetch_odd_addr: assert property ( // [RQ2]
    q.seq && q.ph == crs_pkg::PH_T3_1 |=> cm_init && !cm_we && cm_addr[0] && q.pf && !q.req)
    else $error("current word fetch wrong at t3.1");
  a_store_odd_addr: assert property ( // [RQ3]
    q.seq && q.ph == crs_pkg::PH_T4_1 |=> cm_init && cm_we && cm_addr[0])
    else $error("current word store wrong at t4.1");
  a_term_fetch_even: assert property ( // [RQ7]
    q.seq && q.ph == crs_pkg::PH_T1_1 |=> cm_init && !cm_we && !cm_addr[0] && q.s1 == sec_addr)
    else $error("terminal fetch not even or secondary not loaded");
  a_sec_to_prim: assert property ( // [RQ8]
    q.seq && q.ph == crs_pkg::PH_T2_1 |=> cm_we && cm_addr == $past(q.s1) && !q.seq)
    else $error("t2.1 store not from secondary register");
  a_phase_flag_clr: assert property ( // [RQ15]
    q.ph == crs_pkg::PH_T2_3 |=> !q.pf && !q.inh)
    else $error("phase flag or inhibit not cleared at t2.3");
  // set after t2.2, cleared at the next t2.1: fifteen phases high
  a_seq_length: assert property ( // [RQ6]
    $rose(q.seq) |-> q.seq [*8] ##1 q.seq [*7] ##1 !q.seq)
    else $error("sequence flag length not fifteen phases");
  a_upper_chan: assert property ( // [RQ17]
    q.seq && q.ph == crs_pkg::PH_T3_1 && xl_chan[3] |=> cm_addr[7])
    else $error("upper channel offset missing");
  a_bus_answer: assert property (
    bus_req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");

  c_reload_run: cover property ($rose(q.seq) ##15 $fell(q.seq));
  c_upper_chan: cover property (q.seq && xl_chan[3] && cm_we);
  c_req_waits: cover property (q.req && q.ph == crs_pkg::PH_T2_2 && !start_ok);
  c_bus_read: cover property (avs_read && !avs_waitrequest);

endmodule // crs_sequencer

// file: crs_cm_model.sv
// control memory model that answers the reload sequencer
`timescale 1ns/1ps
module crs_cm_model (
  // clock
  input wire logic clk,
  // requests from the sequencer
  input wire logic cm_init,
  input wire logic cm_we,
  input wire logic [15:0] cm_addr,
  input wire logic [17:0] cm_wdata,
  // bench-side load of the data register, as a transfer sequence fetch would do
  input wire logic prime,
  input wire logic [17:0] prime_word,
  // read answer
  output logic cm_rvalid,
  output logic [17:0] cm_rdata
);
  logic [17:0] mem [0:255];
  logic [17:0] word_q = 18'h0;
  logic rvalid_q = 1'b0;
  // one-cycle read answer, landing in the last cycle of the two-cycle window before the inhibit
  always_ff @(posedge clk)
  begin
    rvalid_q <= prime;
    if (prime)
      word_q <= prime_word;
    if (cm_init && cm_we)
      mem[cm_addr[7:0]] <= cm_wdata;
    if (cm_init && !cm_we)
    begin
      rvalid_q <= 1'b1;
      word_q <= mem[cm_addr[7:0]];
    end
  end
  // outside the answer the data lines show junk, not the last word
  assign cm_rvalid = rvalid_q;
  assign cm_rdata = rvalid_q ? word_q : ~word_q;
endmodule // crs_cm_model

// file: crs_sequencer_tb_top.sv
// self-checking bench for the reload sequencer
`timescale 1ns/1ps
module crs_sequencer_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, cm_rvalid, cm_init, cm_we;
  logic io_seq_active = 1'b0;
  logic [15:0] io_b_addr = 16'h0;
  logic io1_final = 1'b0;
  logic dual_mode = 1'b0;
  logic ext_mode = 1'b0;
  logic term_flag = 1'b0;
  logic cm_free = 1'b1;
  logic [3:0] xl_chan = 4'h0;
  logic xl_output = 1'b0;
  logic prime = 1'b0;
  logic [17:0] prime_word = 18'h0;
  logic [17:0] cm_rdata, cm_wdata;
  logic [15:0] cm_addr;
  logic req_f, seq_f, ph_f;
  logic ovr_lo, ovr_hi;
  logic [3:0] tph;
  int fails = 0;
  int n_tests = 0;
  // clock at 125 MHz
  always #4 clk = ~clk;
  crs_sequencer crs_sequencer_i (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .io_seq_active(io_seq_active), .io_b_addr(io_b_addr), .io1_final(io1_final),
    .dual_mode(dual_mode), .externally_specified_mode(ext_mode), .term_flag(term_flag),
    .xl_chan(xl_chan), .xl_output(xl_output), .cm_free(cm_free), .cm_rvalid(cm_rvalid),
    .cm_rdata(cm_rdata), .cm_init(cm_init), .cm_we(cm_we), .cm_addr(cm_addr),
    .cm_wdata(cm_wdata), .reload_request_flag(req_f), .reload_sequence_flag(seq_f),
    .reload_phase_flag(ph_f), .translator_override_low(ovr_lo),
    .translator_override_high(ovr_hi), .timing_phase(tph));
  crs_cm_model crs_cm_model_i (.clk(clk), .cm_init(cm_init), .cm_we(cm_we),
    .cm_addr(cm_addr), .cm_wdata(cm_wdata), .prime(prime), .prime_word(prime_word),
    .cm_rvalid(cm_rvalid), .cm_rdata(cm_rdata));
  // compare and count
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      chk("bus answer", 32'h0, 32'h1);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // bounded wait for a flag to reach a level
  task automatic wait_flag(ref logic f, input logic v);
    int n;
    n = 0;
    while (f !== v && n < 60)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  // one buffer end on channel k; hold keeps memory busy for a while first
  task automatic reload(input logic [3:0] k, input logic od, input logic mode17,
    input logic hold, input logic [17:0] cw, input logic [17:0] tw);
    logic [7:0] up, rel, dst;
    up = k[3] ? 8'h80 : 8'h00;
    rel = 8'h10 + {4'h0, k[2:0], 1'b0} + up;
    dst = (od ? 8'h60 : 8'h40) + {4'h0, k[2:0], 1'b0} + up;
    crs_cm_model_i.mem[rel] = tw;
    crs_cm_model_i.mem[rel | 8'h01] = cw;
    @(posedge clk);
    xl_chan <= k;
    xl_output <= od;
    io_b_addr <= 16'h1234 + {12'h0, k};
    prime_word <= {mode17, 1'b0, 16'h1234 + {12'h0, k}};
    prime <= 1'b1;
    cm_free <= !hold;
    @(posedge clk);
    prime <= 1'b0;
    io_seq_active <= 1'b1;
    // the request is cleared again at t3.1, so look right after it rises
    wait_flag(req_f, 1'b1);
    io_seq_active <= 1'b0;
    chk("request flag", req_f, mode17);
    if (!mode17)
      return;
    if (hold)
    begin
      repeat (40) @(posedge clk);
      chk("sequence held", seq_f, 1'b0);
      bus(1'b0, crs_pkg::REG_STAT, 32'h0);
      chk("request waits", rd[5:4], 2'b01);
      cm_free <= 1'b1;
    end
    wait_flag(seq_f, 1'b1);
    chk("sequence flag", seq_f, 1'b1);
    chk("phase after start", tph, crs_pkg::PH_T2_3);
    chk("override high forced", ovr_hi, 1'b1);
    chk("override low forced", ovr_lo, 1'b0);
    wait_flag(ph_f, 1'b1);
    chk("request cleared", req_f, 1'b0);
    wait_flag(ph_f, 1'b0);
    chk("sequence cleared", seq_f, 1'b0);
    chk("override high dropped", ovr_hi, 1'b0);
    chk("override low dropped", ovr_lo, 1'b1);
    repeat (2) @(posedge clk);
    chk("current word", crs_cm_model_i.mem[dst | 8'h01], cw);
    chk("terminal word", crs_cm_model_i.mem[dst], tw);
    chk("odd source kept", crs_cm_model_i.mem[rel | 8'h01], cw);
  endtask
  // verdict
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog sized well beyond the few hundred cycles the tests need
  initial
  begin
    #(20000 * 8);
    fails++;
    finish_test();
  end
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, crs_pkg::REG_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    bus(1'b1, crs_pkg::REG_CTRL, 32'h1);
    bus(1'b0, crs_pkg::REG_CTRL, 32'h0);
    chk("ctrl enable", rd[0], 1'b1);
    bus(1'b0, 4'hc, 32'h0);
    chk("unmapped read", rd, 32'h0);
    bus(1'b1, 4'hc, 32'h0);
    bus(1'b0, crs_pkg::REG_CTRL, 32'h0);
    chk("unmapped write", rd[0], 1'b1);
    io1_final <= 1'b1;
    reload(4'h3, 1'b0, 1'b1, 1'b1, 18'h2_0a01, 18'h3_0a40);
    io1_final <= 1'b0;
    dual_mode <= 1'b1;
    reload(4'hb, 1'b1, 1'b1, 1'b0, 18'h1_5501, 18'h2_5580);
    dual_mode <= 1'b0;
    ext_mode <= 1'b1;
    term_flag <= 1'b1;
    reload(4'h5, 1'b0, 1'b1, 1'b0, 18'h0_7701, 18'h3_7720);
    reload(4'h6, 1'b1, 1'b0, 1'b0, 18'h0_0001, 18'h0_0002);
    bus(1'b0, crs_pkg::REG_CNT, 32'h0);
    chk("reload count", rd[15:0], 16'h0003);
    bus(1'b1, crs_pkg::REG_CNT, 32'h0);
    bus(1'b0, crs_pkg::REG_CNT, 32'h0);
    chk("count cleared", rd[15:0], 16'h0000);
    bus(1'b0, crs_pkg::REG_STAT, 32'h0);
    chk("status idle", rd[8:4], 5'h00);
    finish_test();
  end
endmodule // crs_sequencer_tb_top
